//--- shared/gdc_pkg.sv
// constants and types shared by the pin direction control block
package gdc_pkg;

    // ========================================================
    // pin counts
    // ========================================================
    localparam int PIN_COUNT = 12;
    localparam int LOW_PINS = 8;
    localparam int HIGH_PINS = 4;

    // ========================================================
    // register map
    // ========================================================
    localparam logic [7:0] OFF_DIR_LOW = 8'h22;
    localparam logic [7:0] OFF_DIR_HIGH = 8'h23;
    localparam logic [7:0] RESET_DIR_LOW = 8'h00;
    localparam logic [3:0] RESET_DIR_HIGH = 4'h0;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
    localparam logic [3:0] RESERVED_HIGH_BITS = 4'h0;
    localparam logic [PIN_COUNT-1:0] ALL_PINS_ON = 12'hFFF;
    localparam logic [PIN_COUNT-1:0] ALL_PINS_OFF = 12'h000;
    localparam logic [PIN_COUNT-1:0] RESET_PIN_LEVEL = 12'h000;

    // register access request from the host interface logic
    typedef struct packed {
        logic write;
        logic read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } gdc_reg_req_t;

    // register read answer
    typedef struct packed {
        logic valid;
        logic [7:0] rdata;
    } gdc_reg_rsp_t;

endpackage

//--- design/gdc_pin_sync.sv
// two-stage synchroniser for the general purpose pin input levels
module gdc_pin_sync
    import gdc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [PIN_COUNT-1:0] pinAsync,
    output logic [PIN_COUNT-1:0] pinSynced
);

    // ========================================================
    // per-pin flop pair
    // ========================================================
    logic [PIN_COUNT-1:0] syncStage;

    genvar i;
    generate
        for (i = 0; i < PIN_COUNT; i++) begin : g_sync
            // first stage is read only by the second stage
            always_ff @(posedge ref_clk or negedge rstn) begin
                if (!rstn) begin
                    syncStage[i] <= 1'b0;
                    pinSynced[i] <= 1'b0;
                end else begin
                    syncStage[i] <= pinAsync[i];
                    pinSynced[i] <= syncStage[i];
                end
            end
        end
    endgenerate

endmodule

//--- design/gdc_direction_ctrl.sv
// direction registers and pin output enables for the 12-pin port
// Contract
// (R01) direction bit one: pin is an input, its driver stays off.
// (R02) direction bit zero: pin is an output and is driven.
// (R03) high register at 0x23 steers pins 8-11; upper bits reserved; RW; resets 0x00.
// (R04) low register at 0x22, bit n steers pin n; RW; resets 0x00.
// (R05) reads return last written implemented bits; reserved bits read zero, ignore writes.
module gdc_direction_ctrl
    import gdc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input gdc_reg_req_t regReq,
    output gdc_reg_rsp_t regRsp,
    input wire logic [PIN_COUNT-1:0] pinOutValue,
    input wire logic [PIN_COUNT-1:0] pinIn,
    output logic [PIN_COUNT-1:0] pinDrive,
    output logic [PIN_COUNT-1:0] pinOutEn,
    output logic [PIN_COUNT-1:0] pinLevel
);

    // ========================================================
    // direction registers
    // ========================================================
    logic [LOW_PINS-1:0] dirLow;
    logic [HIGH_PINS-1:0] dirHigh;
    logic [PIN_COUNT-1:0] dirAll;
    logic writeLow;
    logic writeHigh;

    // address decode of register writes
    assign writeLow = regReq.write && (regReq.addr == OFF_DIR_LOW);
    assign writeHigh = regReq.write && (regReq.addr == OFF_DIR_HIGH);
    assign dirAll = {dirHigh, dirLow};

    // low register, one bit per pin 0-7
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            dirLow <= RESET_DIR_LOW; // R04
        end else if (writeLow) begin
            dirLow <= regReq.wdata; // R04
        end
    end

    // high register keeps only its low nibble, pins 8-11
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            dirHigh <= RESET_DIR_HIGH; // R03
        end else if (writeHigh) begin
            dirHigh <= regReq.wdata[HIGH_PINS-1:0]; // R03 R05
        end
    end

    // ========================================================
    // register read path
    // ========================================================
    logic [7:0] next_rdata;

    // select read value; reserved and unmapped bits give zero
    always_comb begin
        next_rdata = READ_UNMAPPED;
        if (regReq.addr == OFF_DIR_LOW) begin
            next_rdata = dirLow; // R05
        end else if (regReq.addr == OFF_DIR_HIGH) begin
            next_rdata = {RESERVED_HIGH_BITS, dirHigh}; // R03 R05
        end
    end

    // answer one cycle after the read strobe
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            regRsp <= '0;
        end else begin
            regRsp.valid <= regReq.read;
            if (regReq.read) begin
                regRsp.rdata <= next_rdata;
            end
        end
    end

    // ========================================================
    // pin drivers
    // ========================================================
    // output enable high only where the direction bit is zero
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pinOutEn <= ALL_PINS_ON; // all pins start as outputs
        end else begin
            pinOutEn <= ~dirAll; // R01 R02
        end
    end

    // driven value; forced low on input pins so nothing leaks out
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pinDrive <= RESET_PIN_LEVEL;
        end else begin
            pinDrive <= pinOutValue & ~dirAll; // R01 R02
        end
    end

    // input levels are brought into the clock domain first
    gdc_pin_sync u_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .pinAsync(pinIn),
        .pinSynced(pinLevel)
    );

    // ========================================================
    // assertions
    // ========================================================
    property p_input_not_driven;
        @(posedge ref_clk) disable iff (!rstn)
        1'b1 |=> ((pinOutEn & $past(dirAll)) == ALL_PINS_OFF);
    endproperty
    a_input_not_driven: assert property (p_input_not_driven) // R01
        else $error("input pin has its driver enabled");

    property p_output_driven;
        @(posedge ref_clk) disable iff (!rstn)
        1'b1 |=> ((pinOutEn | $past(dirAll)) == ALL_PINS_ON)
            && ((pinDrive & pinOutEn) == ($past(pinOutValue) & pinOutEn));
    endproperty
    a_output_driven: assert property (p_output_driven) // R02
        else $error("output pin not driven with its value");

    property p_high_write;
        @(posedge ref_clk) disable iff (!rstn)
        (regReq.write && regReq.addr == OFF_DIR_HIGH)
            |-> ##2 (pinOutEn[PIN_COUNT-1:LOW_PINS] == ~$past(regReq.wdata[HIGH_PINS-1:0], 2));
    endproperty
    a_high_write: assert property (p_high_write) // R03
        else $error("high direction write did not reach pins 8-11");

    property p_low_write;
        @(posedge ref_clk) disable iff (!rstn)
        (regReq.write && regReq.addr == OFF_DIR_LOW)
            |-> ##2 (pinOutEn[LOW_PINS-1:0] == ~$past(regReq.wdata, 2));
    endproperty
    a_low_write: assert property (p_low_write) // R04
        else $error("low direction write did not reach pins 0-7");

    property p_readback;
        @(posedge ref_clk) disable iff (!rstn)
        (regReq.write && regReq.addr == OFF_DIR_HIGH) ##1
            (regReq.read && !regReq.write && regReq.addr == OFF_DIR_HIGH)
            |=> regRsp.valid
            && (regRsp.rdata == {RESERVED_HIGH_BITS, $past(regReq.wdata[HIGH_PINS-1:0], 2)});
    endproperty
    a_readback: assert property (p_readback) // R05
        else $error("high register readback wrong or reserved bits set");

    property p_read_answer;
        @(posedge ref_clk) disable iff (!rstn)
        1'b1 |=> (regRsp.valid == $past(regReq.read));
    endproperty
    a_read_answer: assert property (p_read_answer) // R05
        else $error("read answer not valid exactly one cycle after its strobe");

    property p_read_low;
        @(posedge ref_clk) disable iff (!rstn)
        (regReq.read && regReq.addr == OFF_DIR_LOW) |=> (regRsp.rdata == $past(dirLow));
    endproperty
    a_read_low: assert property (p_read_low) // R04
        else $error("low register readback differs from held value");

    property p_read_unmapped;
        @(posedge ref_clk) disable iff (!rstn)
        (regReq.read && regReq.addr != OFF_DIR_LOW && regReq.addr != OFF_DIR_HIGH)
            |=> (regRsp.rdata == READ_UNMAPPED);
    endproperty
    a_read_unmapped: assert property (p_read_unmapped) // R05
        else $error("unmapped read returned nonzero data");

    property p_reserved_zero;
        @(posedge ref_clk) disable iff (!rstn)
        (regReq.read && regReq.addr == OFF_DIR_HIGH)
            |=> ((regRsp.rdata >> HIGH_PINS) == 8'(RESERVED_HIGH_BITS));
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) // R03
        else $error("reserved high register bits read nonzero");

    property p_rdata_hold;
        @(posedge ref_clk) disable iff (!rstn)
        !regReq.read |=> $stable(regRsp.rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) // R05
        else $error("read data changed without a read");

    property p_low_hold;
        @(posedge ref_clk) disable iff (!rstn)
        !writeLow |=> $stable(dirLow);
    endproperty
    a_low_hold: assert property (p_low_hold) // R04
        else $error("low direction register changed without a write");

    property p_high_hold;
        @(posedge ref_clk) disable iff (!rstn)
        !writeHigh |=> $stable(dirHigh);
    endproperty
    a_high_hold: assert property (p_high_hold) // R03
        else $error("high direction register changed without a write");

    property p_unmapped_write;
        @(posedge ref_clk) disable iff (!rstn)
        (regReq.write && regReq.addr != OFF_DIR_LOW && regReq.addr != OFF_DIR_HIGH)
            |=> $stable(dirAll);
    endproperty
    a_unmapped_write: assert property (p_unmapped_write) // R05
        else $error("unmapped write changed a direction bit");

    property p_drive_masked;
        @(posedge ref_clk) disable iff (!rstn)
        1'b1 |=> ((pinDrive & $past(dirAll)) == ALL_PINS_OFF);
    endproperty
    a_drive_masked: assert property (p_drive_masked) // R01
        else $error("input pin shows a nonzero drive value");

    property p_level_sync;
        @(posedge ref_clk) disable iff (!rstn)
        (rstn && $past(rstn)) |=> (pinLevel == $past(pinIn, 2));
    endproperty
    a_level_sync: assert property (p_level_sync) // R01
        else $error("pin level not delayed by two flops");

    c_low_write: cover property (@(posedge ref_clk) disable iff (!rstn) writeLow);
    c_high_write: cover property (@(posedge ref_clk) disable iff (!rstn) writeHigh);
    c_read: cover property (@(posedge ref_clk) disable iff (!rstn) regRsp.valid);
    c_all_inputs: cover property (@(posedge ref_clk) disable iff (!rstn)
        pinOutEn == ALL_PINS_OFF);
    c_write_read: cover property (@(posedge ref_clk) disable iff (!rstn)
        writeHigh ##1 regReq.read);

endmodule

//--- verif/test_gpio_direction_control.sv
// self-checking bench for the pin direction registers and pin enables
`define CHK(nm, ex, sn) begin num_checks++; if ((sn) !== (ex)) begin failures++; \
    $display("ERROR %s expected %h seen %h", nm, ex, sn); end end
module test_gpio_direction_control
    import gdc_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    gdc_reg_req_t regReq = '0;
    gdc_reg_rsp_t regRsp;
    logic [PIN_COUNT-1:0] pinOutValue = '0;
    logic [PIN_COUNT-1:0] pinIn = '0;
    logic [PIN_COUNT-1:0] pinDrive;
    logic [PIN_COUNT-1:0] pinOutEn;
    logic [PIN_COUNT-1:0] pinLevel;
    int failures = 0;
    int num_checks = 0;
    int dirLow = 0;
    int dirHigh = 0;
    logic [31:0] seed = 32'h6D40A03B;
    logic [7:0] rd;
    logic [7:0] ad;
    logic [PIN_COUNT-1:0] levelQ[$];
    logic [PIN_COUNT-1:0] expDir;
    logic [PIN_COUNT-1:0] lvl;
    // ========================================================
    // clock and device
    // ========================================================
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    gdc_direction_ctrl i_dut (.ref_clk(ref_clk), .rstn(rstn), .regReq(regReq),
        .regRsp(regRsp), .pinOutValue(pinOutValue), .pinIn(pinIn), .pinDrive(pinDrive),
        .pinOutEn(pinOutEn), .pinLevel(pinLevel));
    // ========================================================
    // helpers
    // ========================================================
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // one write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk) regReq <= '{1'b1, 1'b0, a, d};
        @(posedge ref_clk) regReq <= '0;
    endtask
    // one read strobe, answer sampled one cycle later
    task automatic rdreg(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk) regReq <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge ref_clk) regReq <= '0;
        #1;
        `CHK("valid", 1'b1, regRsp.valid)
        d = regRsp.rdata;
    endtask
    // model readback: reserved and unmapped places read zero
    function automatic logic [7:0] expRd(input logic [7:0] a);
        return (a == OFF_DIR_LOW) ? dirLow[7:0]
            : (a == OFF_DIR_HIGH) ? {4'h0, dirHigh[3:0]} : 8'h00;
    endfunction
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ========================================================
    // main sequence
    // ========================================================
    initial begin
        repeat (4) @(posedge ref_clk);
        #1;
        `CHK("outEn in reset", 12'hFFF, pinOutEn)
        @(posedge ref_clk) rstn <= 1'b1;
        rdreg(OFF_DIR_LOW, rd);
        `CHK("low reset", 8'h00, rd)
        rdreg(OFF_DIR_HIGH, rd);
        `CHK("high reset", 8'h00, rd)
        $display("test reset done");
        for (int i = 0; i < 30; i++) begin
            seed = lfsr(seed);
            ad = (seed[1:0] == 2'h0) ? OFF_DIR_LOW : seed[15:8];
            ad = (seed[1:0] == 2'h1) ? OFF_DIR_HIGH : ad;
            @(posedge ref_clk) pinOutValue <= seed[27:16];
            wr(ad, seed[7:0]);
            if (ad == OFF_DIR_LOW) dirLow = seed[7:0];
            if (ad == OFF_DIR_HIGH) dirHigh = seed[3:0];
            expDir = {dirHigh[3:0], dirLow[7:0]};
            @(posedge ref_clk);
            #1;
            `CHK("outEn", ~expDir, pinOutEn)
            `CHK("drive", seed[27:16] & ~expDir, pinDrive)
            rdreg(ad, rd);
            `CHK("readback", expRd(ad), rd)
        end
        // write strobe directly followed by a read strobe of the same register
        for (int j = 0; j < 2; j++) begin
            seed = lfsr(seed);
            ad = (j == 0) ? OFF_DIR_LOW : OFF_DIR_HIGH;
            @(posedge ref_clk) regReq <= '{1'b1, 1'b0, ad, seed[7:0]};
            if (j == 0) dirLow = seed[7:0];
            if (j == 1) dirHigh = seed[3:0];
            rdreg(ad, rd);
            `CHK("write then read", expRd(ad), rd)
        end
        $display("test direction done");
        for (int k = 0; k < 40; k++) begin
            seed = lfsr(seed);
            @(posedge ref_clk) pinIn <= seed[11:0];
            levelQ.push_back(seed[11:0]);
            #1;
            if (levelQ.size() > 2) begin
                lvl = levelQ.pop_front();
                `CHK("level", lvl, pinLevel)
            end
        end
        $display("test input level done");
        @(posedge ref_clk) rstn <= 1'b0;
        @(posedge ref_clk) rstn <= 1'b1;
        dirLow = 0;
        dirHigh = 0;
        rdreg(OFF_DIR_LOW, rd);
        `CHK("low after reset", 8'h00, rd)
        rdreg(OFF_DIR_HIGH, rd);
        `CHK("high after reset", 8'h00, rd)
        `CHK("outEn after reset", 12'hFFF, pinOutEn)
        $display("test second reset done");
        end_of_test();
    end
endmodule
